// ---- common/exec_consts.svh ----
// constants for the subtract, nibble swap and table read execution block
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// register map, byte addresses on the plain register port
`define ACC_OFFSET 8'h00
`define FLAGS_OFFSET 8'h04
`define TBL_PTR_OFFSET 8'h08
`define TBL_DATA_OFFSET 8'h0C

// flag bit positions in the flags register
`define FLAG_CARRY_BIT 0
`define FLAG_HALF_BIT 1
`define FLAG_ZERO_BIT 2

// reset values
`define ACC_RESET 8'h00
`define FLAGS_RESET 3'h0
`define TBL_PTR_RESET 3'h0
`define TBL_DATA_RESET 6'h00

// field positions inside a program word
`define ROM_LOW_MSB 7
`define ROM_HIGH_LSB 8
`define ROM_HIGH_MSB 13

// cycles a table read occupies
`define TABLE_READ_CYCLES 2

`endif

// ---- common/exec_pkg.sv ----
// types shared by the execution block
package exec_pkg;

   typedef enum logic [1:0] {
      OP_SUB_REG_MINUS_ACC = 2'b00,
      OP_SUB_IMM_MINUS_ACC = 2'b01,
      OP_NIBBLE_SWAP_REG = 2'b10,
      OP_PROGRAM_ROM_TABLE_READ = 2'b11
   } op_e;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_TABLE = 1'b1
   } phase_e;

   typedef struct packed {
      phase_e phase;
      logic [7:0] accumulator;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
      logic [2:0] table_high_pointer;
      logic [5:0] table_high_data;
      logic [10:0] rom_addr;
      logic rom_re;
      logic reg_we;
      logic [6:0] reg_waddr;
      logic [7:0] reg_wdata;
      logic [31:0] rdata;
      logic done;
   } exec_state_s;

endpackage : exec_pkg

// ---- rtl/subtract_unit.sv ----
// two's complement subtract with no-borrow carry, half carry and zero
module subtract_unit
   import exec_pkg::*;
(
   input wire logic [7:0] minuend_in,    // register or immediate operand
   input wire logic [7:0] subtrahend_in, // accumulator
   output logic [7:0] diff_out,          // minuend minus subtrahend
   output logic carry_out,               // high when no borrow
   output logic half_carry_out,          // high when no low nibble borrow
   output logic zero_out                 // difference is zero
);
   logic [8:0] full_sum;
   logic [4:0] low_sum;

   // a - b done as a + ~b + 1, so the carry out is the inverted borrow
   always_comb begin
      full_sum = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + 9'h001;
      low_sum = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]} + 5'h01;
      diff_out = full_sum[7:0];
      carry_out = full_sum[8];
      half_carry_out = low_sum[4];
      zero_out = (full_sum[7:0] == 8'h00);
   end
endmodule : subtract_unit

// ---- rtl/exec_unit.sv ----
// execution of register/immediate subtract, nibble swap and program rom table read
`include "exec_consts.svh"
module exec_unit
   import exec_pkg::*;
(
   input wire logic clk_in,                 // 10 MHz core clock
   input wire logic rst_in,                 // asynchronous reset, active high
   // instruction issue
   input wire logic op_valid_in,            // one-cycle instruction strobe
   input wire logic [1:0] op_code_in,       // op_e encoding
   input wire logic [6:0] reg_addr_in,      // data-memory register 0..127
   input wire logic dest_in,                // register subtract and swap: 0 accumulator, 1 register
   input wire logic [7:0] imm_in,           // immediate operand
   input wire logic [7:0] reg_data_in,      // current value of the addressed register
   output logic busy_out,                   // second cycle of a table read
   output logic done_out,                   // one-cycle completion pulse
   // register file write back
   output logic reg_we_out,                 // one-cycle write strobe
   output logic [6:0] reg_waddr_out,        // register written
   output logic [7:0] reg_wdata_out,        // value written
   // program rom
   output logic rom_re_out,                 // rom address valid
   output logic [10:0] rom_addr_out,        // {pointer, accumulator}
   input wire logic [13:0] rom_data_in,     // word at rom_addr_out, same cycle
   // core view of the state
   output logic [7:0] accumulator_out,      // accumulator
   output logic zero_flag_out,              // zero flag
   output logic half_carry_flag_out,        // half carry flag
   output logic carry_flag_out,             // carry flag
   output logic [5:0] table_high_data_out,  // table high data
   // register port
   input wire logic [7:0] bus_addr_in,      // byte address
   input wire logic [31:0] bus_wdata_in,    // write data
   input wire logic bus_we_in,              // write strobe
   input wire logic bus_re_in,              // read strobe
   output logic [31:0] bus_rdata_out        // read data, cycle after the strobe
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [7:0] swap_nibbles(input logic [7:0] value);
      return {value[3:0], value[7:4]};
   endfunction : swap_nibbles

   function automatic logic [31:0] read_mux(input logic [7:0] addr, input exec_state_s s);
      logic [31:0] word;
      word = 32'h0000_0000;
      unique case (addr)
         `ACC_OFFSET: word = {24'h00_0000, s.accumulator};
         `FLAGS_OFFSET: begin
            word[`FLAG_CARRY_BIT] = s.carry_flag;
            word[`FLAG_HALF_BIT] = s.half_carry_flag;
            word[`FLAG_ZERO_BIT] = s.zero_flag;
         end
         `TBL_PTR_OFFSET: word = {29'h0, s.table_high_pointer};
         `TBL_DATA_OFFSET: word = {26'h0, s.table_high_data};
         default: word = 32'h0000_0000;
      endcase
      return word;
   endfunction : read_mux

   ////////////////////////////////////////////////////////////////////////////////
   // state

   exec_state_s state;
   exec_state_s next_state;

   logic [7:0] sub_minuend;
   logic [7:0] sub_diff;
   logic sub_carry;
   logic sub_half;
   logic sub_zero;
   op_e op;

   assign op = op_e'(op_code_in);
   // the immediate form shares the one subtractor with the register form
   assign sub_minuend = (op == OP_SUB_IMM_MINUS_ACC) ? imm_in : reg_data_in;

   subtract_unit sub_core (
      .minuend_in(sub_minuend),
      .subtrahend_in(state.accumulator),
      .diff_out(sub_diff),
      .carry_out(sub_carry),
      .half_carry_out(sub_half),
      .zero_out(sub_zero)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [7:0] result;
      result = 8'h00;
      next_state = state;
      next_state.reg_we = 1'b0;
      next_state.done = 1'b0;
      next_state.rom_re = 1'b0;
      next_state.rdata = 32'h0000_0000;

      // register port; an instruction in the same cycle overrides a bus write
      if (bus_re_in) begin
         next_state.rdata = read_mux(bus_addr_in, state);
      end
      if (bus_we_in) begin
         unique case (bus_addr_in)
            `ACC_OFFSET: next_state.accumulator = bus_wdata_in[7:0];
            `FLAGS_OFFSET: begin
               next_state.carry_flag = bus_wdata_in[`FLAG_CARRY_BIT];
               next_state.half_carry_flag = bus_wdata_in[`FLAG_HALF_BIT];
               next_state.zero_flag = bus_wdata_in[`FLAG_ZERO_BIT];
            end
            `TBL_PTR_OFFSET: next_state.table_high_pointer = bus_wdata_in[2:0];
            default: begin
            end
         endcase
      end

      unique case (state.phase)
         ST_IDLE: begin
            // one-cycle instructions finish at the edge that takes them
            if (op_valid_in) begin
               unique case (op)
                  OP_SUB_REG_MINUS_ACC, OP_SUB_IMM_MINUS_ACC: begin
                     result = sub_diff;
                     next_state.carry_flag = sub_carry;
                     next_state.half_carry_flag = sub_half;
                     next_state.zero_flag = sub_zero;
                     if (op == OP_SUB_REG_MINUS_ACC && dest_in) begin
                        next_state.reg_we = 1'b1;
                        next_state.reg_waddr = reg_addr_in;
                        next_state.reg_wdata = result;
                     end else begin
                        next_state.accumulator = result;
                     end
                     next_state.done = 1'b1;
                  end
                  OP_NIBBLE_SWAP_REG: begin
                     result = swap_nibbles(reg_data_in);
                     if (dest_in) begin
                        next_state.reg_we = 1'b1;
                        next_state.reg_waddr = reg_addr_in;
                        next_state.reg_wdata = result;
                     end else begin
                        next_state.accumulator = result;
                     end
                     next_state.done = 1'b1;
                  end
                  OP_PROGRAM_ROM_TABLE_READ: begin
                     // pointer written by the bus in this same cycle is not yet used
                     next_state.rom_addr = {state.table_high_pointer,
                                            state.accumulator};
                     next_state.rom_re = 1'b1;
                     next_state.phase = ST_TABLE;
                  end
               endcase
            end
         end
         ST_TABLE: begin
            // second cycle: rom word is valid beside rom_addr_out; new issue is ignored
            next_state.accumulator = rom_data_in[`ROM_LOW_MSB:0];
            next_state.table_high_data = rom_data_in[`ROM_HIGH_MSB:`ROM_HIGH_LSB];
            next_state.phase = ST_IDLE;
            next_state.done = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state.phase <= ST_IDLE;
         state.accumulator <= `ACC_RESET;
         {state.zero_flag, state.half_carry_flag, state.carry_flag} <= `FLAGS_RESET;
         state.table_high_pointer <= `TBL_PTR_RESET;
         state.table_high_data <= `TBL_DATA_RESET;
         state.rom_addr <= 11'h000;
         state.rom_re <= 1'b0;
         state.reg_we <= 1'b0;
         state.reg_waddr <= 7'h00;
         state.reg_wdata <= 8'h00;
         state.rdata <= 32'h0000_0000;
         state.done <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state flops

   assign busy_out = (state.phase == ST_TABLE);
   assign done_out = state.done;
   assign reg_we_out = state.reg_we;
   assign reg_waddr_out = state.reg_waddr;
   assign reg_wdata_out = state.reg_wdata;
   assign rom_re_out = state.rom_re;
   assign rom_addr_out = state.rom_addr;
   assign accumulator_out = state.accumulator;
   assign zero_flag_out = state.zero_flag;
   assign half_carry_flag_out = state.half_carry_flag;
   assign carry_flag_out = state.carry_flag;
   assign table_high_data_out = state.table_high_data;
   assign bus_rdata_out = state.rdata;

endmodule : exec_unit

// ---- tb/exec_unit_checker.sv ----
// port checker for the execution block
module exec_unit_checker
   import exec_pkg::*;
(
   input wire logic clk_in, // clock
   input wire logic rst_in, // reset
   input wire logic op_valid_in, // strobe
   input wire logic [1:0] op_code_in, // opcode
   input wire logic dest_in, // destination
   input wire logic [7:0] imm_in, // immediate
   input wire logic [7:0] reg_data_in, // register value
   input wire logic busy_out, // busy
   input wire logic done_out, // done
   input wire logic reg_we_out, // write strobe
   input wire logic [7:0] reg_wdata_out, // write data
   input wire logic rom_re_out, // rom read
   input wire logic [10:0] rom_addr_out, // rom address
   input wire logic [13:0] rom_data_in, // rom word
   input wire logic [7:0] accumulator_out, // accumulator
   input wire logic zero_flag_out, // zero
   input wire logic carry_flag_out, // carry
   input wire logic [5:0] table_high_data_out // high data
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic take;
   assign take = op_valid_in && !busy_out;
   ////////////////////////////////////////////////////////////////////////
   a_done_one_cycle: assert property (
      take && op_code_in != 2'h3 |=> done_out && !busy_out)
      else $error("single cycle op did not complete");
   a_table_two_cycle: assert property (
      take && op_code_in == 2'h3 |=> busy_out && !done_out ##1 done_out && !busy_out)
      else $error("table read timing wrong");
   a_rom_addr_form: assert property (
      $rose(busy_out) |-> rom_re_out && rom_addr_out[7:0] == accumulator_out)
      else $error("rom address low byte is not the accumulator");
   a_table_load: assert property (
      rom_re_out |=> {table_high_data_out, accumulator_out} == $past(rom_data_in))
      else $error("table word not loaded");
   a_sub_imm_acc: assert property (
      take && op_code_in == 2'h1
      |=> accumulator_out == 8'($past(imm_in) - $past(accumulator_out)))
      else $error("immediate subtract wrong");
   a_sub_carry_flag: assert property (
      take && op_code_in == 2'h0
      |=> carry_flag_out == ($past(reg_data_in) >= $past(accumulator_out)))
      else $error("subtract carry wrong");
   a_sub_zero_flag: assert property (
      take && op_code_in == 2'h0
      |=> zero_flag_out == ($past(reg_data_in) == $past(accumulator_out)))
      else $error("subtract zero wrong");
   a_swap_to_reg: assert property (
      take && op_code_in == 2'h2 && dest_in
      |=> reg_we_out && {reg_wdata_out[3:0], reg_wdata_out[7:4]} == $past(reg_data_in))
      else $error("swap write back wrong");
   a_swap_keeps_flags: assert property (
      take && op_code_in == 2'h2 |=> $stable(carry_flag_out) && $stable(zero_flag_out))
      else $error("swap changed flags");
   c_table: cover property (take && op_code_in == 2'h3 ##2 done_out);
   c_sub_reg: cover property (take && op_code_in == 2'h0 && dest_in);
   c_swap_acc: cover property (take && op_code_in == 2'h2 && !dest_in);
endmodule : exec_unit_checker

bind exec_unit exec_unit_checker chk (.*);

// ---- tb/subtract_swap_table_read_ops_tb.sv ----
// self-checking bench for the execution block
module subtract_swap_table_read_ops_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import exec_pkg::*;
   logic clk_in, rst_in, op_valid_in, dest_in, bus_we_in, bus_re_in, busy_out, done_out;
   logic reg_we_out, rom_re_out, zero_flag_out, half_carry_flag_out, carry_flag_out;
   logic [1:0] op_code_in;
   logic [6:0] reg_addr_in, reg_waddr_out;
   logic [7:0] imm_in, reg_data_in, reg_wdata_out, accumulator_out, bus_addr_in;
   logic [10:0] rom_addr_out;
   logic [13:0] rom_data_in;
   logic [5:0] table_high_data_out;
   logic [31:0] bus_wdata_in, bus_rdata_out;
   int miscompares = 0, cmp_count = 0, cycles = 0;
   exec_unit dut (.*);
   initial begin
      clk_in = 0;
      forever #50 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus_addr_in <= a; bus_wdata_in <= d; bus_we_in <= 1'b1;
      @(posedge clk_in);
      bus_we_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk_in);
      bus_addr_in <= a; bus_re_in <= 1'b1;
      @(posedge clk_in);
      bus_re_in <= 1'b0;
      #1 chk(nm, exp, bus_rdata_out);
   endtask : rd
   // returns just after the edge that ends the strobe cycle
   task automatic op(input logic [1:0] c, input logic d, input logic [7:0] i, input logic [7:0] r);
      @(posedge clk_in);
      op_valid_in <= 1'b1; op_code_in <= c; dest_in <= d; imm_in <= i; reg_data_in <= r;
      reg_addr_in <= 7'h7F;
      @(posedge clk_in);
      op_valid_in <= 1'b0;
      #1;
   endtask : op
   // flags word: zero bit 2, half carry bit 1, carry bit 0
   function automatic logic [31:0] fl(input logic [7:0] m, input logic [7:0] s);
      return {29'h0, m == s, m[3:0] >= s[3:0], m >= s};
   endfunction : fl
   ////////////////////////////////////////////////////////////////////////
   task automatic t_sub_reg();
      wr(8'h00, 32'h06);
      op(2'h0, 1'b1, 8'h00, 8'h05);
      chk("done", 1, done_out);
      chk("we", 1, reg_we_out);
      chk("wdata", 8'hFF, reg_wdata_out);
      chk("waddr", 7'h7F, reg_waddr_out);
      chk("carry", 0, carry_flag_out);
      rd(8'h00, 32'h06, "acc kept");
      op(2'h0, 1'b0, 8'h00, 8'h06);
      chk("acc", 8'h00, accumulator_out);
      chk("we off", 0, reg_we_out);
      rd(8'h04, fl(8'h06, 8'h06), "flags");
   endtask : t_sub_reg
   task automatic t_sub_imm();
      wr(8'h00, 32'h01);
      op(2'h1, 1'b1, 8'h10, 8'h00);
      chk("acc", 8'h0F, accumulator_out);
      chk("half", 0, half_carry_flag_out);
      rd(8'h04, fl(8'h10, 8'h01), "flags");
      op(2'h1, 1'b0, 8'h05, 8'h00);
      op(2'h1, 1'b0, 8'h00, 8'h00);
      chk("acc b2b", 8'h0A, accumulator_out);
   endtask : t_sub_imm
   task automatic t_swap();
      wr(8'h04, 32'h07);
      op(2'h2, 1'b1, 8'h00, 8'hA5);
      chk("we", 1, reg_we_out);
      chk("wdata", 8'h5A, reg_wdata_out);
      op(2'h2, 1'b0, 8'h00, 8'hC3);
      chk("acc", 8'h3C, accumulator_out);
      rd(8'h04, 32'h07, "flags kept");
   endtask : t_swap
   task automatic t_table();
      wr(8'h08, 32'h02);
      wr(8'h00, 32'h34);
      // strobe right after the pointer and accumulator writes
      op_valid_in <= 1'b1;
      op_code_in <= 2'h3;
      dest_in <= 1'b0;
      @(posedge clk_in);
      // strobe held on into the busy cycle as a subtract: it must be dropped
      op_code_in <= 2'h1;
      imm_in <= 8'hFF;
      rom_data_in <= 14'h35AA;
      #1 chk("busy", 1, busy_out);
      chk("rom re", 1, rom_re_out);
      chk("rom addr", 11'h234, rom_addr_out);
      @(posedge clk_in);
      op_valid_in <= 1'b0;
      rom_data_in <= 14'h0A55;
      #1 chk("done", 1, done_out);
      chk("acc", 8'hAA, accumulator_out);
      chk("high data", 6'h35, table_high_data_out);
      @(posedge clk_in);
      #1 chk("dropped", 9'h0AA, {done_out, accumulator_out});
      wr(8'h0C, 32'h00);
      rd(8'h0C, 32'h35, "high data ro");
      rd(8'h10, 32'h00, "unmapped");
   endtask : t_table
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      rst_in = 1; op_valid_in = 0; op_code_in = 0; dest_in = 0; imm_in = 0; reg_data_in = 0;
      reg_addr_in = 0; rom_data_in = 0; bus_addr_in = 0; bus_wdata_in = 0; bus_we_in = 0;
      bus_re_in = 0;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0, "reset value");
      t_sub_reg();
      t_sub_imm();
      t_swap();
      t_table();
      close_out();
   end
endmodule : subtract_swap_table_read_ops_tb
